// [tb/aos_host_model.sv]
`timescale 1ns/1ps
// ------
// host feed, one entry a cycle
// ------
module aos_host_model (
	input  wire        clk,
	input  wire        wr_ready_ff,
	output reg         wr_valid,
	output reg  [15:0] wr_data
);
	reg [15:0] q[$];
	initial begin
		wr_valid = 1'b0;
		wr_data = 16'h0000;
	end
	always @(posedge clk) begin
		if (wr_valid && wr_ready_ff)
			q.delete(0);
		wr_valid <= q.size() != 0;
		// idle data inverted so no stale entry looks valid
		wr_data <= (q.size() != 0) ? q[0] : ~wr_data;
	end
endmodule

// [tb/aos_seq_checker.sv]
`timescale 1ns/1ps
// ------
// port checks
// ------
module aos_seq_checker (
	input wire        clk,
	input wire        srst,
	input wire [1:0]  mode,
	input wire        cascade,
	input wire [15:0] divisor_b,
	input wire [11:0] dac0_ff,
	input wire [11:0] dac3_ff,
	input wire [3:0]  dac_load_ff,
	input wire        sync_out_ff,
	input wire        burst_busy_ff,
	input wire        thr_flag_ff,
	input wire        empty_ff,
	input wire        gen_a_pulse_ff,
	input wire        gen_b_pulse_ff
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);
	sync_mark_a: assert property (sync_out_ff == (dac_load_ff != 4'h0))
		else $error("sync output not paired with a dac load");
	dac0_hold_a: assert property ($changed(dac0_ff) |-> dac_load_ff[0])
		else $error("dac0 changed without load");
	dac3_hold_a: assert property ($changed(dac3_ff) |-> dac_load_ff[3])
		else $error("dac3 changed without load");
	burst_gate_a: assert property (dac_load_ff != 4'h0 && mode[0] |-> $past(burst_busy_ff))
		else $error("burst load outside a burst");
	seq_single_a: assert property (dac_load_ff != 4'h0 && mode[1] |-> $onehot(dac_load_ff))
		else $error("sequential load hit several dacs");
	thr_empty_a: assert property (empty_ff |-> thr_flag_ff)
		else $error("threshold flag low while empty");
	gen_gap_a: assert property (gen_a_pulse_ff |=> !gen_a_pulse_ff [*3])
		else $error("generator a pulses too close");
	casc_gap_a: assert property (gen_b_pulse_ff && cascade && $past(cascade, 3) && divisor_b == 16'h0001
		|=> !gen_b_pulse_ff [*7])
		else $error("cascaded generator b pulses too close");
	reset_vals_a: assert property (disable iff (1'b0) srst |=> dac_load_ff == 4'h0 && !sync_out_ff && empty_ff)
		else $error("outputs not at reset values");
endmodule
bind aos_sequencer aos_seq_checker chk (
	.clk            (clk),
	.srst           (srst),
	.mode           (mode),
	.cascade        (cascade),
	.divisor_b      (divisor_b),
	.dac0_ff        (dac0_ff),
	.dac3_ff        (dac3_ff),
	.dac_load_ff    (dac_load_ff),
	.sync_out_ff    (sync_out_ff),
	.burst_busy_ff  (burst_busy_ff),
	.thr_flag_ff    (thr_flag_ff),
	.empty_ff       (empty_ff),
	.gen_a_pulse_ff (gen_a_pulse_ff),
	.gen_b_pulse_ff (gen_b_pulse_ff)
);

// [tb/aos_sequencer_tb.sv]
`timescale 1ns/1ps
module aos_sequencer_tb;
	reg clk = 1'b0, srst = 1'b1, enable = 1'b0, cascade = 1'b0;
	reg soft_clk = 1'b0, soft_sync = 1'b0, ext_sync_in = 1'b0;
	reg [1:0] mode = 2'h0, clk_src = 2'h1;
	reg [3:0] threshold = 4'h1;
	wire wr_valid, wr_ready, busy, thr, empty, ga, gb, sync, irq;
	wire [15:0] wr_data;
	wire [11:0] dac [0:3];
	wire [3:0] dac_load;
	integer fails = 0, total_checks = 0, load_cnt = 0, seen = 0, sync_cnt = 0;
	reg [3:0] last_mask = 4'h0;
	aos_host_model host (.clk(clk), .wr_ready_ff(wr_ready), .wr_valid(wr_valid), .wr_data(wr_data));
	aos_sequencer #(.AW(4)) uut (
		.clk(clk), .srst(srst), .enable(enable), .mode(mode), .clk_src(clk_src),
		.gen_sel(1'b0), .cascade(cascade), .divisor_a(16'h0003), .divisor_b(16'h0001),
		.soft_clk(soft_clk), .soft_sync(soft_sync), .ext_sync_in(ext_sync_in),
		.wr_valid(wr_valid), .wr_data(wr_data), .threshold(threshold), .irq_enable(4'hf),
		.wr_ready_ff(wr_ready), .dac0_ff(dac[0]), .dac1_ff(dac[1]), .dac2_ff(dac[2]),
		.dac3_ff(dac[3]), .dac_load_ff(dac_load), .sync_out_ff(sync), .burst_busy_ff(busy),
		.thr_flag_ff(thr), .empty_ff(empty), .irq_ff(irq), .gen_a_pulse_ff(ga), .gen_b_pulse_ff(gb)
	);
	always #25 clk = ~clk;
	always @(posedge clk) if (dac_load != 4'h0) begin
		load_cnt = load_cnt + 1;
		last_mask = dac_load;
	end
	always @(posedge clk) if (sync) sync_cnt = sync_cnt + 1;
	// ------
	// helpers
	// ------
	function [15:0] e(input b, input g, input [1:0] t, input [11:0] v);
		e = {b, g, t, v};
	endfunction
	task chk(input [47:0] what, input [15:0] exp, input [15:0] got);
		begin
			total_checks = total_checks + 1;
			if (got !== exp) begin
				fails = fails + 1;
				$display("BAD %0s exp %h got %h", what, exp, got);
			end
		end
	endtask
	task tick(input integer n);
		repeat (n) @(negedge clk);
	endtask
	task wl(input [3:0] m);
		integer n;
		begin
			n = 0;
			while (load_cnt == seen && n < 80) begin
				@(negedge clk);
				n = n + 1;
			end
			chk("load", {12'h0, m}, {12'h0, last_mask});
			seen = load_cnt;
		end
	endtask
	task nol;
		begin
			tick(20);
			chk("noload", seen[15:0], load_cnt[15:0]);
		end
	endtask
	// pulse width one cycle; 0 soft clock, 1 soft sync, 2 external
	task pul(input [1:0] w);
		begin
			@(posedge clk);
			soft_clk <= w == 2'h0;
			soft_sync <= w == 2'h1;
			ext_sync_in <= w == 2'h2;
			@(posedge clk);
			{soft_clk, soft_sync, ext_sync_in} <= 3'b000;
			tick(1);
		end
	endtask
	task cfg(input [1:0] m, input [1:0] s);
		begin
			@(posedge clk);
			mode <= m;
			clk_src <= s;
			tick(1);
		end
	endtask
	task gap(input b, input [15:0] exp);
		integer n;
		begin
			n = 0;
			while (!(b ? gb : ga) && n < 99) begin
				@(negedge clk);
				n = n + 1;
			end
			n = 0;
			do begin
				@(negedge clk);
				n = n + 1;
			end while (!(b ? gb : ga) && n < 99);
			chk("gap", exp, n[15:0]);
		end
	endtask
	// ------
	// scenarios
	// ------
	task t_sim;
		integer i;
		begin
			for (i = 0; i < 4; i = i + 1)
				host.q.push_back(e(1'b0, i == 3, i[1:0], 12'h5a0 + i[11:0]));
			tick(12);
			chk("held", 16'h0, {4'h0, dac[0]});
			pul(2'h0);
			wl(4'hf);
			for (i = 0; i < 4; i = i + 1)
				chk("dac", {4'h0, 12'h5a0 + i[11:0]}, {4'h0, dac[i]});
			host.q.push_back(e(1'b0, 1'b0, 2'h1, 12'h123));
			tick(10);
			pul(2'h0);
			nol;
			host.q.push_back(e(1'b0, 1'b1, 2'h2, 12'h456));
			cfg(2'h0, 2'h2);
			tick(10);
			pul(2'h2);
			wl(4'h6);
			chk("dac1", 16'h0123, {4'h0, dac[1]});
		end
	endtask
	task t_gen;
		begin
			cfg(2'h0, 2'h0);
			host.q.push_back(e(1'b0, 1'b1, 2'h3, 12'h0c3));
			wl(4'h8);
			gap(1'b0, 16'h0004);
			@(posedge clk);
			cascade <= 1'b1;
			tick(20);
			gap(1'b1, 16'h0008);
			@(posedge clk);
			cascade <= 1'b0;
		end
	endtask
	task t_burst;
		begin
			cfg(2'h1, 2'h0);
			host.q.push_back(e(1'b0, 1'b0, 2'h0, 12'h111));
			host.q.push_back(e(1'b0, 1'b1, 2'h1, 12'h222));
			host.q.push_back(e(1'b0, 1'b0, 2'h0, 12'h333));
			host.q.push_back(e(1'b1, 1'b1, 2'h1, 12'h444));
			nol;
			pul(2'h1);
			wl(4'h3);
			chk("dac0", 16'h0111, {4'h0, dac[0]});
			wl(4'h3);
			chk("dac1", 16'h0444, {4'h0, dac[1]});
			tick(4);
			chk("busy", 16'h0, {15'h0, busy});
			host.q.push_back(e(1'b1, 1'b1, 2'h2, 12'h555));
			nol;
			pul(2'h2);
			wl(4'h4);
		end
	endtask
	task t_seq;
		begin
			cfg(2'h2, 2'h1);
			host.q.push_back(e(1'b0, 1'b1, 2'h2, 12'h777));
			host.q.push_back(e(1'b0, 1'b0, 2'h0, 12'h888));
			tick(8);
			pul(2'h0);
			wl(4'h4);
			chk("dac2", 16'h0777, {4'h0, dac[2]});
			pul(2'h0);
			wl(4'h1);
			cfg(2'h3, 2'h0);
			host.q.push_back(e(1'b1, 1'b0, 2'h1, 12'h999));
			pul(2'h1);
			wl(4'h2);
		end
	endtask
	task t_thr;
		integer i;
		begin
			cfg(2'h2, 2'h3);
			for (i = 0; i < 3; i = i + 1)
				host.q.push_back(e(1'b0, 1'b0, 2'h0, 12'h0a0));
			tick(8);
			chk("thr", 16'h0, {15'h0, thr});
			chk("irq", 16'h0, {15'h0, irq});
			cfg(2'h2, 2'h1);
			pul(2'h0);
			pul(2'h0);
			tick(3);
			chk("thr", 16'h1, {15'h0, thr});
			pul(2'h0);
			tick(3);
			chk("empty", 16'h1, {15'h0, empty});
			chk("sync", 16'h000c, sync_cnt[15:0]);
		end
	endtask
	task test_done;
		begin
			if (fails == 0 && total_checks > 0)
				$display("SIMULATION PASSED");
			else
				$display("SIMULATION FAILED");
			$finish;
		end
	endtask
	initial begin
		repeat (16) @(posedge clk);
		srst <= 1'b0;
		enable <= 1'b1;
		tick(2);
		chk("thr", 16'h1, {15'h0, thr});
		chk("dac3", 16'h0, {4'h0, dac[3]});
		chk("irq", 16'h1, {15'h0, irq});
		t_sim;
		t_gen;
		t_burst;
		t_seq;
		t_thr;
		test_done;
	end
	// run needs a few hundred cycles; cut off at four thousand
	initial begin
		#(50 * 4000);
		fails = fails + 1;
		test_done;
	end
endmodule

// [verilog/aos_fifo.v]
`timescale 1ns/1ps
`include "aos_regs.vh"
module aos_fifo #(
	parameter AW = `AOS_FIFO_AW,
	parameter DW = `AOS_ENT_W
) (
	input  wire          clk,
	input  wire          srst,
	input  wire          wr_valid,
	output wire          wr_ready,
	input  wire [DW-1:0] wr_data,
	input  wire          rd_take,
	output wire          rd_valid,
	output wire [DW-1:0] rd_data,
	output wire [AW:0]   level
);
	reg [DW-1:0] mem [0:(1<<AW)-1];
	reg [AW:0]   wp_ff;
	reg [AW:0]   rp_ff;
	wire         do_wr;
	wire         do_rd;
	// ----------------------------------------
	// pointers with wrap bit for honest full
	// ----------------------------------------
	assign level    = wp_ff - rp_ff;
	assign wr_ready = (level != {1'b1, {AW{1'b0}}});
	assign rd_valid = (level != {(AW+1){1'b0}});
	assign rd_data  = mem[rp_ff[AW-1:0]];
	assign do_wr    = wr_valid && wr_ready;
	assign do_rd    = rd_take && rd_valid;
	always @(posedge clk) begin
		if (do_wr) begin
			mem[wp_ff[AW-1:0]] <= wr_data;
		end
	end
	always @(posedge clk) begin
		if (srst) begin
			wp_ff <= {(AW+1){1'b0}};
			rp_ff <= {(AW+1){1'b0}};
		end else begin
			if (do_wr) begin
				wp_ff <= wp_ff + {{AW{1'b0}}, 1'b1};
			end
			if (do_rd) begin
				rp_ff <= rp_ff + {{AW{1'b0}}, 1'b1};
			end
		end
	end
endmodule

// [verilog/aos_rate_gen.v]
`timescale 1ns/1ps
`include "aos_regs.vh"
module aos_rate_gen #(
	parameter W = 16
) (
	input  wire         clk,
	input  wire         srst,
	input  wire         en,
	input  wire         tick_in,
	input  wire [W-1:0] divisor,
	output reg          pulse_ff
);
	reg [W-1:0] cnt_ff;
	// ----------------------------------------
	// divide by divisor+1 advances of tick_in
	// ----------------------------------------
	always @(posedge clk) begin
		if (srst || !en) begin
			cnt_ff   <= {W{1'b0}};
			pulse_ff <= 1'b0;
		end else begin
			pulse_ff <= 1'b0;
			if (tick_in) begin
				if (cnt_ff >= divisor) begin
					cnt_ff   <= {W{1'b0}};
					pulse_ff <= 1'b1;
				end else begin
					cnt_ff <= cnt_ff + {{(W-1){1'b0}}, 1'b1};
				end
			end
		end
	end
endmodule

// [verilog/aos_regs.vh]
`ifndef AOS_REGS_VH
`define AOS_REGS_VH
// ----------------------------------------
// entry layout
// ----------------------------------------
`define AOS_ENT_W        16
`define AOS_DATA_MSB     11
`define AOS_DATA_LSB     0
`define AOS_TAG_MSB      13
`define AOS_TAG_LSB      12
`define AOS_GEND_BIT     14
`define AOS_BEND_BIT     15
// ----------------------------------------
// mode and source codes
// ----------------------------------------
`define AOS_MODE_SIM_CONT 2'h0
`define AOS_MODE_SIM_BRST 2'h1
`define AOS_MODE_SEQ_CONT 2'h2
`define AOS_MODE_SEQ_BRST 2'h3
`define AOS_SRC_RGEN     2'h0
`define AOS_SRC_SOFT     2'h1
`define AOS_SRC_EXT      2'h2
// ----------------------------------------
// sizes and reset values
// ----------------------------------------
`define AOS_FIFO_AW      15
`define AOS_THR_RST      15'h0000
`define AOS_DIV_RST      16'h0000
`define AOS_DAC_RST      12'h000
`endif

// [verilog/aos_sequencer.v]
`timescale 1ns/1ps
`include "aos_regs.vh"
module aos_sequencer #(
	parameter AW = `AOS_FIFO_AW,
	parameter DW = `AOS_ENT_W,
	parameter GW = 16
) (
	input  wire          clk,
	input  wire          srst,
	input  wire          enable,
	input  wire [1:0]    mode,
	input  wire [1:0]    clk_src,
	input  wire          gen_sel,
	input  wire          cascade,
	input  wire [GW-1:0] divisor_a,
	input  wire [GW-1:0] divisor_b,
	input  wire          soft_clk,
	input  wire          soft_sync,
	input  wire          ext_sync_in,
	input  wire          wr_valid,
	input  wire [DW-1:0] wr_data,
	input  wire [AW-1:0] threshold,
	input  wire [3:0]    irq_enable,
	output reg           wr_ready_ff,
	output reg  [11:0]   dac0_ff,
	output reg  [11:0]   dac1_ff,
	output reg  [11:0]   dac2_ff,
	output reg  [11:0]   dac3_ff,
	output reg  [3:0]    dac_load_ff,
	output reg           sync_out_ff,
	output reg           burst_busy_ff,
	output reg           thr_flag_ff,
	output reg           empty_ff,
	output reg           irq_ff,
	output reg           gen_a_pulse_ff,
	output reg           gen_b_pulse_ff
);
	// ----------------------------------------
	// input synchronisers
	// ----------------------------------------
	reg        ext_m_ff;
	reg        ext_s_ff;
	reg        ext_d_ff;
	wire       ext_edge;
	always @(posedge clk) begin
		if (srst) begin
			ext_m_ff <= 1'b0;
			ext_s_ff <= 1'b0;
			ext_d_ff <= 1'b0;
		end else begin
			ext_m_ff <= ext_sync_in;
			ext_s_ff <= ext_m_ff;
			ext_d_ff <= ext_s_ff;
		end
	end
	assign ext_edge = ext_s_ff && !ext_d_ff;

	// ----------------------------------------
	// rate generators
	// ----------------------------------------
	wire pulse_a;
	wire pulse_b;
	wire tick_b;
	assign tick_b = cascade ? pulse_a : 1'b1;
	aos_rate_gen #(.W(GW)) u_gen_a (
		.clk      (clk),
		.srst     (srst),
		.en       (enable),
		.tick_in  (1'b1),
		.divisor  (divisor_a),
		.pulse_ff (pulse_a)
	);
	aos_rate_gen #(.W(GW)) u_gen_b (
		.clk      (clk),
		.srst     (srst),
		.en       (enable),
		.tick_in  (tick_b),
		.divisor  (divisor_b),
		.pulse_ff (pulse_b)
	);
	// cascade forces b: a alone gives only the fast range
	wire gen_pulse;
	assign gen_pulse = (gen_sel || cascade) ? pulse_b : pulse_a;
	always @(posedge clk) begin
		if (srst) begin
			gen_a_pulse_ff <= 1'b0;
			gen_b_pulse_ff <= 1'b0;
		end else begin
			gen_a_pulse_ff <= pulse_a;
			gen_b_pulse_ff <= pulse_b;
		end
	end

	// ----------------------------------------
	// sample buffer
	// ----------------------------------------
	wire          fifo_ready;
	wire          fifo_valid;
	wire [DW-1:0] fifo_data;
	wire [AW:0]   fifo_level;
	reg           take;
	wire          acc_wr;
	wire [AW:0]   level_after;
	// accept only on the flopped ready the host sees, so both sides agree
	assign acc_wr      = wr_valid && wr_ready_ff;
	assign level_after = fifo_level + {{AW{1'b0}}, acc_wr} - {{AW{1'b0}}, take && fifo_valid};
	aos_fifo #(.AW(AW), .DW(DW)) u_fifo (
		.clk      (clk),
		.srst     (srst),
		.wr_valid (acc_wr),
		.wr_ready (fifo_ready),
		.wr_data  (wr_data),
		.rd_take  (take),
		.rd_valid (fifo_valid),
		.rd_data  (fifo_data),
		.level    (fifo_level)
	);
	wire [1:0]  ent_tag;
	wire [11:0] ent_val;
	wire        ent_gend;
	wire        ent_bend;
	assign ent_tag  = fifo_data[`AOS_TAG_MSB:`AOS_TAG_LSB];
	assign ent_val  = fifo_data[`AOS_DATA_MSB:`AOS_DATA_LSB];
	assign ent_gend = fifo_data[`AOS_GEND_BIT];
	assign ent_bend = fifo_data[`AOS_BEND_BIT];

	// ----------------------------------------
	// output clock selection
	// ----------------------------------------
	wire is_burst;
	wire is_seq;
	reg  out_clk;
	assign is_burst = (mode == `AOS_MODE_SIM_BRST) || (mode == `AOS_MODE_SEQ_BRST);
	assign is_seq   = (mode == `AOS_MODE_SEQ_CONT) || (mode == `AOS_MODE_SEQ_BRST);
	always @* begin
		case (clk_src)
			`AOS_SRC_RGEN: out_clk = gen_pulse;
			`AOS_SRC_SOFT: out_clk = soft_clk;
			`AOS_SRC_EXT:  out_clk = ext_edge;
			default:       out_clk = 1'b0;
		endcase
	end
	wire start_sync;
	assign start_sync = soft_sync || ext_edge;

	// ----------------------------------------
	// gather and transfer state machine
	// ----------------------------------------
	localparam ST_IDLE   = 2'h0;
	localparam ST_GATHER = 2'h1;
	localparam ST_READY  = 2'h2;
	reg [1:0]  st_ff;
	reg [1:0]  nxt_st;
	reg [11:0] hold_ff [0:3];
	reg [3:0]  hmask_ff;
	reg        last_bend_ff;
	reg        nxt_last_bend;
	reg        running;
	reg        fire;
	integer    i;

	// bursts use only the generator; continuous uses the chosen source
	always @* begin
		nxt_st        = st_ff;
		nxt_last_bend = last_bend_ff;
		take          = 1'b0;
		fire          = 1'b0;
		running       = enable && (!is_burst || burst_busy_ff);
		case (st_ff)
			ST_IDLE: begin
				if (enable) begin
					nxt_st = ST_GATHER;
				end
			end
			ST_GATHER: begin
				if (!running) begin
					nxt_st = enable ? ST_GATHER : ST_IDLE;
				end else if (is_seq) begin
					// sequential: one entry per clock, no grouping
					if ((is_burst ? gen_pulse : out_clk) && fifo_valid) begin
						take = 1'b1;
						fire = 1'b1;
						nxt_last_bend = ent_bend;
					end
				end else if (fifo_valid) begin
					take = 1'b1;
					nxt_last_bend = ent_bend;
					if (ent_gend || ent_bend) begin
						nxt_st = ST_READY;
					end
				end
			end
			ST_READY: begin
				// switch to a sequential mode: drop back, no fire on a stale head
				if (is_seq) begin
					nxt_st = ST_GATHER;
				end else if ((is_burst ? gen_pulse : out_clk)) begin
					fire   = 1'b1;
					nxt_st = ST_GATHER;
				end
				if (!enable) begin
					nxt_st = ST_IDLE;
				end
			end
			default: nxt_st = ST_IDLE;
		endcase
	end

	always @(posedge clk) begin
		if (srst) begin
			st_ff         <= ST_IDLE;
			hmask_ff      <= 4'h0;
			last_bend_ff  <= 1'b0;
			burst_busy_ff <= 1'b0;
			dac0_ff       <= `AOS_DAC_RST;
			dac1_ff       <= `AOS_DAC_RST;
			dac2_ff       <= `AOS_DAC_RST;
			dac3_ff       <= `AOS_DAC_RST;
			dac_load_ff   <= 4'h0;
			sync_out_ff   <= 1'b0;
			for (i = 0; i < 4; i = i + 1) begin
				hold_ff[i] <= `AOS_DAC_RST;
			end
		end else begin
			st_ff        <= nxt_st;
			last_bend_ff <= nxt_last_bend;
			dac_load_ff  <= 4'h0;
			sync_out_ff  <= fire;
			if (take && !is_seq) begin
				hold_ff[ent_tag]   <= ent_val;
				hmask_ff[ent_tag]  <= 1'b1;
			end
			if (fire && is_seq) begin
				case (ent_tag)
					2'h0: dac0_ff <= ent_val;
					2'h1: dac1_ff <= ent_val;
					2'h2: dac2_ff <= ent_val;
					default: dac3_ff <= ent_val;
				endcase
				dac_load_ff <= 4'h1 << ent_tag;
			end else if (fire) begin
				// only channels present in the group change
				if (hmask_ff[0]) dac0_ff <= hold_ff[0];
				if (hmask_ff[1]) dac1_ff <= hold_ff[1];
				if (hmask_ff[2]) dac2_ff <= hold_ff[2];
				if (hmask_ff[3]) dac3_ff <= hold_ff[3];
				dac_load_ff <= hmask_ff;
				hmask_ff    <= 4'h0;
			end
			// empty buffer and no group waiting in ST_READY: no fire, dacs keep their values
			if (!enable || !is_burst) begin
				burst_busy_ff <= 1'b0;
			end else if (!burst_busy_ff && start_sync) begin
				burst_busy_ff <= 1'b1;
			end else if (fire && (is_seq ? ent_bend : last_bend_ff)) begin
				burst_busy_ff <= 1'b0;
			end
		end
	end

	// ----------------------------------------
	// buffer status and interrupt request
	// ----------------------------------------
	// irq_enable: 0 threshold, 1 empty, 2 burst done, 3 full
	wire thr_now;
	wire burst_done;
	assign thr_now    = (fifo_level <= {1'b0, threshold});
	assign burst_done = burst_busy_ff && is_burst && fire && (is_seq ? ent_bend : last_bend_ff);
	always @(posedge clk) begin
		if (srst) begin
			thr_flag_ff <= 1'b1;
			empty_ff    <= 1'b1;
			wr_ready_ff <= 1'b0;
			irq_ff      <= 1'b0;
		end else begin
			thr_flag_ff <= thr_now;
			empty_ff    <= !fifo_valid;
			// ready looks one cycle ahead so a flopped ready never overfills
			wr_ready_ff <= (level_after != {1'b1, {AW{1'b0}}});
			irq_ff      <= (irq_enable[0] && thr_now) || (irq_enable[1] && !fifo_valid) ||
			               (irq_enable[2] && burst_done) || (irq_enable[3] && !fifo_ready);
		end
	end
endmodule
